//--- sccc_cfg.svh
`ifndef SCCC_CFG_SVH
`define SCCC_CFG_SVH
`define SCCC_CLK_MHZ 250
`define SCCC_DEV_ADDR 7'h2C
`define SCCC_NUM_REGS 7
`define SCCC_OFS_RED_OFFSET 8'h0D
`define SCCC_OFS_SYNC_CTRL 8'h0E
`define SCCC_OFS_LOOP_CLAMP 8'h0F
`define SCCC_OFS_SLICER 8'h10
`define SCCC_OFS_SEP_THR 8'h11
`define SCCC_OFS_PRE_COAST 8'h12
`define SCCC_OFS_POST_COAST 8'h13
`define SCCC_OFS_STATUS 8'h14
`define SCCC_RST_RED_OFFSET 8'h80
`define SCCC_RST_SYNC_CTRL 8'h5B
`define SCCC_RST_LOOP_CLAMP 8'h2E
`define SCCC_RST_SLICER 8'h5D
`define SCCC_RST_SEP_THR 8'h20
`define SCCC_RST_PRE_COAST 8'h00
`define SCCC_RST_POST_COAST 8'h00
`define SCCC_B_HPOL_OVR 7
`define SCCC_B_HPOL_IN 6
`define SCCC_B_HPOL_OUT 5
`define SCCC_B_HSRC_MAN 4
`define SCCC_B_HSRC_SEL 3
`define SCCC_B_VPOL_OUT 2
`define SCCC_B_VSRC_MAN 1
`define SCCC_B_VSRC_SEL 0
`define SCCC_B_CLAMP_SRC 7
`define SCCC_B_CLAMP_POL 6
`define SCCC_B_COAST_SEL 5
`define SCCC_B_CPOL_OVR 4
`define SCCC_B_CPOL_SEL 3
`define SCCC_B_SEEK_OVR 2
`define SCCC_B_FULL_PD_N 1
`define SCCC_B_ADC_TEST 0
`define SCCC_OFFSET_ZERO 12'h200
`define SCCC_MID_BLANK 10'h200
`define SCCC_HACT_US 100
`define SCCC_VACT_MS 100
`define SCCC_CLAMP_START 8'h32
`define SCCC_CLAMP_WIDTH 8'h20
`endif

//--- sccc_pkg.sv
`default_nettype none
package sccc_pkg;
  typedef enum logic [2:0] {
    SCCC_IDLE = 3'h0,
    SCCC_ADDR = 3'h1,
    SCCC_SUB = 3'h2,
    SCCC_WRITE = 3'h3,
    SCCC_READ = 3'h4
  } sccc_i2c_t;
endpackage
`default_nettype wire

//--- sccc_top.sv
`include "sccc_cfg.svh"
`default_nettype none
module sccc_top #(
  parameter logic [6:0] DEV_ADDR = `SCCC_DEV_ADDR,
  parameter int HACT_CYC = `SCCC_HACT_US * `SCCC_CLK_MHZ,
  parameter int VACT_CYC = `SCCC_VACT_MS * 1000 * `SCCC_CLK_MHZ,
  parameter logic [7:0] CLAMP_START = `SCCC_CLAMP_START,
  parameter logic [7:0] CLAMP_WIDTH = `SCCC_CLAMP_WIDTH
) (
  input wire logic MCLK_IN,
  input wire logic RST_IN,
  input wire logic CE_IN,
  input wire logic SCL_IN,
  input wire logic SDA_IN,
  input wire logic HSYNC_IN,
  input wire logic SOG_IN,
  input wire logic VSYNC_IN,
  input wire logic CLAMP_IN,
  input wire logic COAST_IN,
  input wire logic REF_TICK_IN,
  input wire logic RAW_BYPASS_IN,
  output logic SDA_OUT,
  output logic SDA_OE_OUT,
  output logic HS_OUT,
  output logic VS_OUT,
  output logic COAST_OUT,
  output logic LOOP_HOLD_OUT,
  output logic PHASE_STEP_OUT,
  output logic FINE_CLAMP_OUT,
  output logic COARSE_CLAMP_OUT,
  output logic EXT_CLK_SEL_OUT,
  output logic [2:0] CLAMP_MID_OUT,
  output logic [4:0] SLICER_LEVEL_OUT,
  output logic [7:0] RED_OFFSET_OUT,
  output logic [9:0] RED_BLANK_OUT,
  output logic LOW_POWER_OUT,
  output logic FULL_PD_OUT
);
  localparam logic [7:0] RST_VAL [`SCCC_NUM_REGS] = '{`SCCC_RST_RED_OFFSET, `SCCC_RST_SYNC_CTRL,
    `SCCC_RST_LOOP_CLAMP, `SCCC_RST_SLICER, `SCCC_RST_SEP_THR, `SCCC_RST_PRE_COAST, `SCCC_RST_POST_COAST};

  sccc_pkg::sccc_i2c_t state_ff;
  logic scl_prev_ff, sda_prev_ff, rw_ff, nack_ff, wr_ff;
  logic [3:0] bit_cnt_ff;
  logic [7:0] shift_ff, tx_ff, sub_ff, wr_addr_ff, wr_data_ff, rd_data, rd_idx, status;
  logic [7:0] reg_ff [`SCCC_NUM_REGS];
  logic [7:0] r_sync, r_loop, r_slice, r_thr, r_pre, r_post;
  logic i2c_start, i2c_stop, scl_rise, scl_fall;
  logic [3:0] mon_in, mon_act, mon_pol;

  assign r_sync = reg_ff[1];
  assign r_loop = reg_ff[2];
  assign r_slice = reg_ff[3];
  assign r_thr = reg_ff[4];
  assign r_pre = reg_ff[5];
  assign r_post = reg_ff[6];

  // Serial bus conditions
  assign i2c_start = SCL_IN & scl_prev_ff & sda_prev_ff & ~SDA_IN;
  assign i2c_stop = SCL_IN & scl_prev_ff & ~sda_prev_ff & SDA_IN;
  assign scl_rise = SCL_IN & ~scl_prev_ff;
  assign scl_fall = ~SCL_IN & scl_prev_ff;

  assign rd_idx = sub_ff - `SCCC_OFS_RED_OFFSET;
  always_comb
  begin
    if (sub_ff >= `SCCC_OFS_RED_OFFSET && sub_ff <= `SCCC_OFS_POST_COAST)
      rd_data = reg_ff[rd_idx[2:0]];
    else if (sub_ff == `SCCC_OFS_STATUS)
      rd_data = status;
    else
      rd_data = 8'h00;
  end

  always_ff @(posedge MCLK_IN)
  begin
    if (RST_IN)
    begin
      scl_prev_ff <= 1'b1;
      sda_prev_ff <= 1'b1;
    end
    else if (CE_IN)
    begin
      scl_prev_ff <= SCL_IN;
      sda_prev_ff <= SDA_IN;
    end
  end

  // Serial slave with auto-incrementing subaddress
  always_ff @(posedge MCLK_IN)
  begin
    if (RST_IN)
    begin
      state_ff <= sccc_pkg::SCCC_IDLE;
      bit_cnt_ff <= 4'h0;
      shift_ff <= 8'h00;
      tx_ff <= 8'h00;
      sub_ff <= 8'h00;
      rw_ff <= 1'b0;
      nack_ff <= 1'b0;
      wr_ff <= 1'b0;
      wr_addr_ff <= 8'h00;
      wr_data_ff <= 8'h00;
      SDA_OE_OUT <= 1'b0;
    end
    else if (CE_IN)
    begin
      wr_ff <= 1'b0;
      if (i2c_start)
      begin
        state_ff <= sccc_pkg::SCCC_ADDR;
        bit_cnt_ff <= 4'h0;
        SDA_OE_OUT <= 1'b0;
      end
      else if (i2c_stop)
      begin
        state_ff <= sccc_pkg::SCCC_IDLE;
        SDA_OE_OUT <= 1'b0;
      end
      // Bits counted on clock rise, so the fall after START is ignored
      else if (state_ff != sccc_pkg::SCCC_IDLE && scl_rise)
      begin
        if (bit_cnt_ff < 4'h8)
        begin
          shift_ff <= {shift_ff[6:0], SDA_IN};
          bit_cnt_ff <= bit_cnt_ff + 4'h1;
        end
        else if (bit_cnt_ff == 4'h8)
        begin
          nack_ff <= SDA_IN;
          bit_cnt_ff <= 4'h9;
        end
      end
      else if (state_ff != sccc_pkg::SCCC_IDLE && scl_fall)
      begin
        if (bit_cnt_ff == 4'h8)
        begin
          case (state_ff)
            sccc_pkg::SCCC_ADDR:
            begin
              if (shift_ff[7:1] == DEV_ADDR)
              begin
                SDA_OE_OUT <= 1'b1;
                rw_ff <= shift_ff[0];
              end
              else
                state_ff <= sccc_pkg::SCCC_IDLE;
            end
            sccc_pkg::SCCC_SUB:
            begin
              sub_ff <= shift_ff;
              SDA_OE_OUT <= 1'b1;
            end
            sccc_pkg::SCCC_WRITE:
            begin
              wr_ff <= 1'b1;
              wr_addr_ff <= sub_ff;
              wr_data_ff <= shift_ff;
              sub_ff <= sub_ff + 8'h01;
              SDA_OE_OUT <= 1'b1;
            end
            default:
              SDA_OE_OUT <= 1'b0;
          endcase
        end
        else if (bit_cnt_ff == 4'h9)
        begin
          bit_cnt_ff <= 4'h0;
          SDA_OE_OUT <= 1'b0;
          case (state_ff)
            sccc_pkg::SCCC_ADDR:
            begin
              state_ff <= rw_ff ? sccc_pkg::SCCC_READ : sccc_pkg::SCCC_SUB;
              if (rw_ff)
              begin
                tx_ff <= rd_data;
                SDA_OE_OUT <= ~rd_data[7];
                sub_ff <= sub_ff + 8'h01;
              end
            end
            sccc_pkg::SCCC_SUB:
              state_ff <= sccc_pkg::SCCC_WRITE;
            sccc_pkg::SCCC_READ:
            begin
              if (nack_ff)
                state_ff <= sccc_pkg::SCCC_IDLE;
              else
              begin
                tx_ff <= rd_data;
                SDA_OE_OUT <= ~rd_data[7];
                sub_ff <= sub_ff + 8'h01;
              end
            end
            default:
              state_ff <= state_ff;
          endcase
        end
        else if (bit_cnt_ff != 4'h0 && state_ff == sccc_pkg::SCCC_READ)
          SDA_OE_OUT <= ~tx_ff[3'h7 - bit_cnt_ff[2:0]];
      end
    end
  end

  // Register bank, contents kept through power-down
  // registers retained
  for (genvar i = 0; i < `SCCC_NUM_REGS; i++)
  begin : g_reg
    always_ff @(posedge MCLK_IN)
    begin
      if (RST_IN)
        reg_ff[i] <= RST_VAL[i];
      else if (CE_IN && wr_ff && wr_addr_ff == `SCCC_OFS_RED_OFFSET + 8'(i))
        reg_ff[i] <= wr_data_ff;
    end
  end

  // Activity and polarity monitors: hsync, green sync, vsync, coast
  assign mon_in = {COAST_IN, VSYNC_IN, SOG_IN, HSYNC_IN};
  for (genvar g = 0; g < 4; g++)
  begin : g_mon
    localparam logic [24:0] LIM = (g < 2) ? 25'(HACT_CYC) : 25'(VACT_CYC);
    logic prev_ff, act_ff;
    logic [24:0] run_ff, hi_ff, lo_ff;
    always_ff @(posedge MCLK_IN)
    begin
      if (RST_IN)
      begin
        // Start at pin level, no false edge after reset
        prev_ff <= mon_in[g];
        act_ff <= 1'b0;
        run_ff <= 25'h0;
        hi_ff <= 25'h0;
        lo_ff <= 25'h0;
      end
      else if (CE_IN)
      begin
        prev_ff <= mon_in[g];
        if (mon_in[g] != prev_ff)
        begin
          run_ff <= 25'h0;
          act_ff <= 1'b1;
          if (prev_ff)
            hi_ff <= run_ff;
          else
            lo_ff <= run_ff;
        end
        else
        begin
          if (run_ff != LIM)
            run_ff <= run_ff + 25'h1;
          else
            act_ff <= 1'b0;
        end
      end
    end
    // Short high phase means active-high pulses
    assign mon_pol[g] = hi_ff < lo_ff;
    assign mon_act[g] = act_ff;
  end

  // Source choice and normalised syncs
  logic ahs_ff, avs_ff, hpol, cpol, hs_act, vs_act, coast_ext, clamp_ext;
  logic sep_vs_ff, sog_prev_ff, hs_prev_ff, vs_prev_ff;
  logic [7:0] sep_cnt_ff;
  always_ff @(posedge MCLK_IN)
  begin
    if (RST_IN)
    begin
      ahs_ff <= 1'b1;
      avs_ff <= 1'b1;
    end
    else if (CE_IN)
    begin
      if (r_sync[`SCCC_B_HSRC_MAN])
        ahs_ff <= r_sync[`SCCC_B_HSRC_SEL];
      else
        ahs_ff <= ~mon_act[0] & mon_act[1];
      if (r_sync[`SCCC_B_VSRC_MAN])
        avs_ff <= r_sync[`SCCC_B_VSRC_SEL];
      else
        avs_ff <= ~mon_act[2];
    end
  end

  assign hpol = r_sync[`SCCC_B_HPOL_OVR] ? r_sync[`SCCC_B_HPOL_IN] : mon_pol[0];
  assign hs_act = ahs_ff ? ~SOG_IN : ~(HSYNC_IN ^ hpol);
  assign vs_act = avs_ff ? sep_vs_ff : ~(VSYNC_IN ^ mon_pol[2]);
  assign cpol = r_loop[`SCCC_B_CPOL_OVR] ? r_loop[`SCCC_B_CPOL_SEL] : mon_pol[3];
  assign coast_ext = ~(COAST_IN ^ cpol);
  assign clamp_ext = CLAMP_IN ^ r_loop[`SCCC_B_CLAMP_POL];

  always_ff @(posedge MCLK_IN)
  begin
    if (RST_IN)
    begin
      sog_prev_ff <= 1'b1;
      sep_cnt_ff <= 8'h00;
      sep_vs_ff <= 1'b0;
    end
    else if (CE_IN)
    begin
      sog_prev_ff <= SOG_IN;
      if (SOG_IN != sog_prev_ff)
        sep_cnt_ff <= 8'h00;
      else if (REF_TICK_IN && sep_cnt_ff != r_thr)
        sep_cnt_ff <= sep_cnt_ff + 8'h01;
      else if (sep_cnt_ff == r_thr)
        sep_vs_ff <= ~SOG_IN;
    end
  end

  // Line counting and internal coast
  logic coast_int_ff, coast;
  logic [11:0] line_ff, frame_ff;
  logic [7:0] post_cnt_ff;
  logic hs_rise, vs_rise, vs_fall;
  assign hs_rise = hs_act & ~hs_prev_ff;
  assign vs_rise = vs_act & ~vs_prev_ff;
  assign vs_fall = ~vs_act & vs_prev_ff;
  always_ff @(posedge MCLK_IN)
  begin
    if (RST_IN)
    begin
      hs_prev_ff <= 1'b0;
      vs_prev_ff <= 1'b0;
      line_ff <= 12'h000;
      frame_ff <= 12'h000;
    end
    else if (CE_IN)
    begin
      hs_prev_ff <= hs_act;
      vs_prev_ff <= vs_act;
      if (vs_rise)
      begin
        // Coincident line edge counted too
        frame_ff <= line_ff + {11'h000, hs_rise};
        line_ff <= 12'h000;
      end
      else if (hs_rise)
        line_ff <= line_ff + 12'h001;
    end
  end

  always_ff @(posedge MCLK_IN)
  begin
    if (RST_IN)
    begin
      coast_int_ff <= 1'b0;
      post_cnt_ff <= 8'h00;
    end
    else if (CE_IN)
    begin
      if (r_pre == 8'h00)
      begin
        coast_int_ff <= 1'b0;
        post_cnt_ff <= 8'h00;
      end
      else if (vs_act)
        coast_int_ff <= 1'b1;
      else if (vs_fall)
      begin
        post_cnt_ff <= r_post;
        coast_int_ff <= r_post != 8'h00;
      end
      else if (hs_rise)
      begin
        if (post_cnt_ff != 8'h00)
        begin
          post_cnt_ff <= post_cnt_ff - 8'h01;
          coast_int_ff <= post_cnt_ff != 8'h01;
        end
        else if (frame_ff != 12'h000 && 13'(line_ff) + 13'h1 + 13'(r_pre) >= 13'(frame_ff))
          coast_int_ff <= 1'b1;
      end
    end
  end
  assign coast = r_loop[`SCCC_B_COAST_SEL] ? coast_int_ff : coast_ext;

  // Internal clamp window after horizontal trailing edge
  logic [8:0] clp_cnt_ff;
  logic clp_run_ff, clamp_int, clamp;
  always_ff @(posedge MCLK_IN)
  begin
    if (RST_IN)
    begin
      clp_cnt_ff <= 9'h000;
      clp_run_ff <= 1'b0;
    end
    else if (CE_IN)
    begin
      if (~hs_act & hs_prev_ff)
      begin
        clp_cnt_ff <= 9'h000;
        clp_run_ff <= 1'b1;
      end
      else if (clp_run_ff)
      begin
        clp_cnt_ff <= clp_cnt_ff + 9'h001;
        if (clp_cnt_ff == 9'(CLAMP_START) + 9'(CLAMP_WIDTH))
          clp_run_ff <= 1'b0;
      end
    end
  end
  assign clamp_int = clp_run_ff && clp_cnt_ff >= 9'(CLAMP_START) &&
    clp_cnt_ff < 9'(CLAMP_START) + 9'(CLAMP_WIDTH);
  assign clamp = r_loop[`SCCC_B_CLAMP_SRC] ? clamp_ext : clamp_int;

  // Status byte
  // discrete activity flag
  assign status = {mon_act[0], ahs_ff, mon_pol[0], mon_act[2], avs_ff, mon_pol[2], mon_act[1], mon_pol[3]};

  // Red blank code from offset and clamp level
  logic [11:0] blank_sum;
  assign blank_sum = 12'(r_slice[0] ? `SCCC_MID_BLANK : 10'h000) + {2'h0, reg_ff[0], 2'h0} - `SCCC_OFFSET_ZERO;

  logic sel_idle;
  assign sel_idle = ~(ahs_ff ? mon_act[1] : mon_act[0]) | ~(avs_ff ? mon_act[1] : mon_act[2]);

  // Registered outputs
  always_ff @(posedge MCLK_IN)
  begin
    if (RST_IN)
    begin
      SDA_OUT <= 1'b0;
      HS_OUT <= 1'b1;
      VS_OUT <= 1'b1;
      COAST_OUT <= 1'b0;
      LOOP_HOLD_OUT <= 1'b0;
      PHASE_STEP_OUT <= 1'b0;
      FINE_CLAMP_OUT <= 1'b0;
      COARSE_CLAMP_OUT <= 1'b0;
      EXT_CLK_SEL_OUT <= 1'b0;
      CLAMP_MID_OUT <= 3'h5;
      SLICER_LEVEL_OUT <= 5'h0B;
      RED_OFFSET_OUT <= `SCCC_RST_RED_OFFSET;
      RED_BLANK_OUT <= 10'h000;
      LOW_POWER_OUT <= 1'b0;
      FULL_PD_OUT <= 1'b0;
    end
    else if (CE_IN)
    begin
      SDA_OUT <= 1'b0;
      HS_OUT <= RAW_BYPASS_IN ? (ahs_ff ? SOG_IN : HSYNC_IN) : ~(hs_act ^ r_sync[`SCCC_B_HPOL_OUT]);
      VS_OUT <= ~(vs_act ^ r_sync[`SCCC_B_VPOL_OUT]);
      COAST_OUT <= coast;
      LOOP_HOLD_OUT <= coast;
      PHASE_STEP_OUT <= hs_rise & ~coast;
      FINE_CLAMP_OUT <= clamp & ~r_loop[`SCCC_B_ADC_TEST];
      COARSE_CLAMP_OUT <= r_loop[`SCCC_B_ADC_TEST];
      EXT_CLK_SEL_OUT <= r_loop[`SCCC_B_ADC_TEST];
      CLAMP_MID_OUT <= r_slice[2:0];
      SLICER_LEVEL_OUT <= r_slice[7:3];
      RED_OFFSET_OUT <= reg_ff[0];
      RED_BLANK_OUT <= blank_sum[11] ? 10'h000 : blank_sum[9:0];
      LOW_POWER_OUT <= ~r_loop[`SCCC_B_SEEK_OVR] & sel_idle;
      FULL_PD_OUT <= ~r_loop[`SCCC_B_FULL_PD_N];
    end
  end
endmodule
`default_nettype wire

//--- sccc_checker.sv
`default_nettype none
module sccc_checker (
  input wire logic MCLK_IN,
  input wire logic RST_IN,
  input wire logic SCL_IN,
  input wire logic SDA_OE_OUT,
  input wire logic HS_OUT,
  input wire logic VS_OUT,
  input wire logic COAST_OUT,
  input wire logic LOOP_HOLD_OUT,
  input wire logic PHASE_STEP_OUT,
  input wire logic FINE_CLAMP_OUT,
  input wire logic COARSE_CLAMP_OUT,
  input wire logic EXT_CLK_SEL_OUT,
  input wire logic [2:0] CLAMP_MID_OUT,
  input wire logic [4:0] SLICER_LEVEL_OUT,
  input wire logic [7:0] RED_OFFSET_OUT,
  input wire logic [9:0] RED_BLANK_OUT,
  input wire logic FULL_PD_OUT
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking dcb @(posedge MCLK_IN);
  endclocking
  default disable iff (RST_IN);
  logic [1:0] stab_ff;
  logic [1:0] nxt_stab;
  function automatic logic [9:0] blank_of(input logic [7:0] off, input logic mid);
    int v;
    v = (mid ? 0 : -512) + 4 * int'(off);
    v = (v < 0) ? 0 : ((v > 1023) ? 1023 : v);
    return v[9:0];
  endfunction
  always_comb
  begin
    nxt_stab = (stab_ff == 2'h3) ? stab_ff : stab_ff + 2'h1;
  end
  // Cycles since offset or red clamp mode last moved
  always_ff @(posedge MCLK_IN)
  begin
    if (RST_IN || $changed(RED_OFFSET_OUT) || $changed(CLAMP_MID_OUT[0]))
    begin
      stab_ff <= 2'h0;
    end
    else
    begin
      stab_ff <= nxt_stab;
    end
  end
  AST_RST_OFFSET: assert property ($past(RST_IN) |-> RED_OFFSET_OUT == 8'h80)
    else $error("red offset not at reset value");
  AST_BLANK_LEVEL: assert property (stab_ff[1] |-> RED_BLANK_OUT == blank_of(RED_OFFSET_OUT, CLAMP_MID_OUT[0]))
    else $error("red blank level wrong");
  AST_RST_SYNC_OUT: assert property ($past(RST_IN) |-> HS_OUT && VS_OUT)
    else $error("sync outputs not idle after reset");
  AST_RST_POWER: assert property ($past(RST_IN) |-> !FULL_PD_OUT && !COARSE_CLAMP_OUT)
    else $error("power or test state wrong after reset");
  AST_RST_SLICER: assert property ($past(RST_IN) |-> SLICER_LEVEL_OUT == 5'h0B)
    else $error("slicer level not at reset value");
  AST_RST_CLAMP_SEL: assert property ($past(RST_IN) |-> CLAMP_MID_OUT == 3'h5)
    else $error("clamp select not at reset value");
  AST_TEST_PAIR: assert property (COARSE_CLAMP_OUT == EXT_CLK_SEL_OUT)
    else $error("coarse clamp and clock select differ");
  AST_TEST_NO_FINE: assert property (COARSE_CLAMP_OUT && $past(COARSE_CLAMP_OUT) |-> !FINE_CLAMP_OUT)
    else $error("fine clamp active in test mode");
  AST_HOLD_IS_COAST: assert property ($stable(COAST_OUT) |-> LOOP_HOLD_OUT == COAST_OUT)
    else $error("loop hold differs from coast");
  AST_NO_STEP_IN_COAST: assert property (LOOP_HOLD_OUT && $past(LOOP_HOLD_OUT) |-> !PHASE_STEP_OUT)
    else $error("phase step while coasting");
  AST_STEP_PULSE: assert property (PHASE_STEP_OUT |=> !PHASE_STEP_OUT)
    else $error("phase step longer than one cycle");
  AST_BUS_QUIET: assert property ($changed(SDA_OE_OUT) |-> !SCL_IN)
    else $error("data line moved while serial clock high");
  COVER_COAST: cover property ($rose(COAST_OUT));
  COVER_STEP: cover property (PHASE_STEP_OUT);
  COVER_TEST: cover property (COARSE_CLAMP_OUT && !FINE_CLAMP_OUT);
endmodule
bind sccc_top sccc_checker u_sccc_checker (.MCLK_IN, .RST_IN, .SCL_IN, .SDA_OE_OUT, .HS_OUT, .VS_OUT,
  .COAST_OUT, .LOOP_HOLD_OUT, .PHASE_STEP_OUT, .FINE_CLAMP_OUT, .COARSE_CLAMP_OUT, .EXT_CLK_SEL_OUT,
  .CLAMP_MID_OUT, .SLICER_LEVEL_OUT, .RED_OFFSET_OUT, .RED_BLANK_OUT, .FULL_PD_OUT);
`default_nettype wire

//--- sccc_video_src.sv
`default_nettype none
module sccc_video_src #(
  parameter int LINE = 40,
  parameter int LINES = 10
) (
  input wire logic clk_in,
  input wire logic hs_en_in,
  input wire logic sog_en_in,
  input wire logic vs_en_in,
  input wire logic hs_lvl_in,
  output logic hsync_out = 1'b0,
  output logic sog_out = 1'b1,
  output logic vsync_out = 1'b0,
  output logic ref_tick_out = 1'b0
);
  timeunit 1ns;
  timeprecision 1ps;
  int px = 0;
  int ln = 0;
  // Raster of lines and frames, stopped hsync holds hs_lvl_in, stopped green sync and vsync hold idle
  always @(posedge clk_in)
  begin
    px <= (px == LINE - 1) ? 0 : px + 1;
    if (px == LINE - 1)
    begin
      ln <= (ln == LINES - 1) ? 0 : ln + 1;
    end
    hsync_out <= hs_en_in ? (px < 4) : hs_lvl_in;
    sog_out <= !(sog_en_in && px < 4);
    vsync_out <= vs_en_in && ln < 2;
    ref_tick_out <= px[1:0] == 2'h0;
  end
endmodule
`default_nettype wire

//--- sync_clamp_coast_control_tb.sv
`include "sccc_cfg.svh"
`default_nettype none
module sync_clamp_coast_control_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [6:0] DEV = `SCCC_DEV_ADDR;
  logic clk = 1'b0, rst = 1'b1, scl = 1'b1, sda_m = 1'b1, bypass = 1'b0;
  logic hs_en = 1'b0, sog_en = 1'b0, vs_en = 1'b0, hs_lvl = 1'b0, clamp_p = 1'b0, coast_p = 1'b0;
  logic hsync, green_embedded_sync, vsync, rtick, sda_o, sda_oe, hs_o, coast_o, fine_o, coarse_o, pd_o, vs_o, lp_o;
  logic [2:0] mid_o;
  logic [4:0] slc_o;
  logic [7:0] off_o;
  logic [9:0] blank_o;
  logic [7:0] regs [256];
  logic [7:0] offs [5] = '{8'h00, 8'h7F, 8'h80, 8'h81, 8'hFF};
  int mismatches = 0, checks = 0, coast_cnt = 0, fine_cnt = 0;
  wire logic sda_w = sda_m & !(sda_oe & !sda_o);
  sccc_top #(.HACT_CYC(64), .VACT_CYC(2000), .CLAMP_START(8'h06), .CLAMP_WIDTH(8'h04)) u_sccc_top (
    .MCLK_IN(clk), .RST_IN(rst), .CE_IN(1'b1), .SCL_IN(scl), .SDA_IN(sda_w), .HSYNC_IN(hsync),
    .SOG_IN(green_embedded_sync), .VSYNC_IN(vsync), .CLAMP_IN(clamp_p), .COAST_IN(coast_p), .REF_TICK_IN(rtick),
    .RAW_BYPASS_IN(bypass), .SDA_OUT(sda_o), .SDA_OE_OUT(sda_oe), .HS_OUT(hs_o), .VS_OUT(vs_o),
    .COAST_OUT(coast_o), .LOOP_HOLD_OUT(), .PHASE_STEP_OUT(), .FINE_CLAMP_OUT(fine_o),
    .COARSE_CLAMP_OUT(coarse_o), .EXT_CLK_SEL_OUT(), .CLAMP_MID_OUT(mid_o), .SLICER_LEVEL_OUT(slc_o),
    .RED_OFFSET_OUT(off_o), .RED_BLANK_OUT(blank_o), .LOW_POWER_OUT(lp_o), .FULL_PD_OUT(pd_o));
  sccc_video_src u_sccc_video_src (.clk_in(clk), .hs_en_in(hs_en), .sog_en_in(sog_en),
    .vs_en_in(vs_en), .hs_lvl_in(hs_lvl), .hsync_out(hsync), .sog_out(green_embedded_sync), .vsync_out(vsync),
    .ref_tick_out(rtick));
  initial forever #2 clk = ~clk;
  always @(posedge clk)
  begin
    coast_cnt <= coast_cnt + int'(coast_o);
    fine_cnt <= fine_cnt + int'(fine_o);
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic chk(input logic [9:0] s, input logic [9:0] e);
    checks++;
    if (s !== e)
    begin
      mismatches++;
      $display("[ERR] %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic bit_io(input logic b, output logic r);
    sda_m <= b;
    cyc(4);
    scl <= 1'b1;
    cyc(4);
    r = sda_w;
    scl <= 1'b0;
    cyc(4);
  endtask
  task automatic start();
    sda_m <= 1'b1;
    cyc(4);
    scl <= 1'b1;
    cyc(4);
    sda_m <= 1'b0;
    cyc(4);
    scl <= 1'b0;
    cyc(4);
  endtask
  task automatic stop();
    sda_m <= 1'b0;
    cyc(4);
    scl <= 1'b1;
    cyc(4);
    sda_m <= 1'b1;
    cyc(4);
  endtask
  task automatic tx(input logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--)
      bit_io(d[i], r);
    bit_io(1'b1, r);
    chk(10'(r), 10'h000);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    start();
    tx({DEV, 1'b0});
    tx(a);
    tx(d);
    stop();
    if (a >= 8'h0D && a <= 8'h13)
      regs[a] = d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    logic r;
    start();
    tx({DEV, 1'b0});
    tx(a);
    start();
    tx({DEV, 1'b1});
    for (int i = 7; i >= 0; i--)
    begin
      bit_io(1'b1, r);
      d[i] = r;
    end
    bit_io(1'b1, r);
    stop();
  endtask
  task automatic rd_all();
    logic [7:0] d;
    for (int a = 8'h0D; a <= 8'h14; a++)
    begin
      rd((a == 8'h14) ? 8'h20 : 8'(a), d);
      chk(10'(d), 10'(regs[(a == 8'h14) ? 8'h20 : 8'(a)]));
    end
  endtask
  task automatic outs();
    int b;
    cyc(4);
    b = (regs[8'h10][0] ? 0 : -512) + 4 * int'(regs[8'h0D]);
    b = (b < 0) ? 0 : ((b > 1023) ? 1023 : b);
    chk(10'(off_o), 10'(regs[8'h0D]));
    chk(blank_o, 10'(b));
    chk(10'(mid_o), 10'(regs[8'h10][2:0]));
    chk(10'(slc_o), 10'(regs[8'h10][7:3]));
    chk(10'(pd_o), 10'(!regs[8'h0F][1]));
    chk(10'(coarse_o), 10'(regs[8'h0F][0]));
  endtask
  task automatic close_out();
    $display("mismatches %0d checks %0d", mismatches, checks);
    if (mismatches == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial
  begin
    cyc(90000);
    mismatches++;
    close_out();
  end
  initial
  begin
    logic [7:0] d;
    int n;
    int m;
    void'($urandom(13758));
    for (int i = 0; i < 256; i++)
      regs[i] = 8'h00;
    regs[8'h0D] = 8'h80;
    regs[8'h0E] = 8'h5B;
    regs[8'h0F] = 8'h2E;
    regs[8'h10] = 8'h5D;
    regs[8'h11] = 8'h20;
    cyc(4);
    rst <= 1'b0;
    cyc(2);
    outs();
    rd_all();
    repeat (2)
    begin
      for (int a = 8'h0D; a <= 8'h14; a++)
        wr((a == 8'h14) ? 8'h20 : 8'(a), 8'($urandom));
      rd_all();
      outs();
    end
    for (int i = 0; i < 10; i++)
    begin
      wr(8'h0D, offs[i % 5]);
      wr(8'h10, {5'h0B, 2'b10, 1'(i / 5)});
      outs();
    end
    wr(8'h0F, 8'h2E);
    for (int i = 0; i < 16; i++)
    begin
      wr(8'h0E, {1'b1, i[3], i[2], 5'b10010});
      bypass <= i[1];
      hs_lvl <= i[0];
      cyc(8);
      chk(10'(hs_o), 10'(i[1] ? i[0] : (i[2] ? i[0] == i[3] : i[0] != i[3])));
    end
    bypass <= 1'b0;
    for (int i = 0; i < 32; i++)
    begin
      wr(8'h0F, {1'b1, i[3], 2'b01, i[2], 2'b11, i[4]});
      clamp_p <= i[1];
      coast_p <= i[0];
      cyc(8);
      chk(10'(fine_o), 10'(!i[4] && (i[1] ^ i[3])));
      chk(10'(coarse_o), 10'(i[4]));
      chk(10'(coast_o), 10'(i[0] == i[2]));
    end
    hs_en <= 1'b1;
    sog_en <= 1'b1;
    vs_en <= 1'b1;
    wr(8'h0F, 8'h2E);
    wr(8'h0E, 8'h52);
    wr(8'h11, 8'h40);
    cyc(400);
    n = fine_cnt;
    cyc(400);
    chk(10'(fine_cnt - n), 10'h028);
    wr(8'h0E, 8'h40);
    cyc(500);
    rd(8'h14, d);
    chk(10'(d[7:6]), 10'h002);
    chk(10'(d[3]), 10'h000);
    wr(8'h0E, 8'h58);
    rd(8'h14, d);
    chk(10'(d[6]), 10'h001);
    hs_en <= 1'b0;
    vs_en <= 1'b0;
    wr(8'h0E, 8'h40);
    cyc(2500);
    rd(8'h14, d);
    chk(10'(d[7:6]), 10'h001);
    chk(10'(d[3]), 10'h001);
    wr(8'h0E, 8'h56);
    chk(10'(vs_o), 10'h000);
    chk(10'(lp_o), 10'h000);
    wr(8'h0F, 8'h2A);
    chk(10'(lp_o), 10'h001);
    hs_en <= 1'b1;
    vs_en <= 1'b1;
    wr(8'h0E, 8'h52);
    wr(8'h13, 8'h00);
    wr(8'h12, 8'h01);
    cyc(1200);
    n = coast_cnt;
    cyc(2000);
    m = coast_cnt - n;
    chk(10'(m), 10'h258);
    wr(8'h13, 8'h03);
    cyc(1200);
    n = coast_cnt;
    cyc(2000);
    chk(10'(coast_cnt - n > m + 300), 10'h001);
    wr(8'h12, 8'h00);
    wr(8'h13, 8'h00);
    cyc(800);
    n = coast_cnt;
    cyc(2000);
    chk(10'(coast_cnt - n), 10'h000);
    chk(10'(lp_o), 10'h000);
    outs();
    close_out();
  end
endmodule
`default_nettype wire
